//--- cgsc_pkg.sv
package cgsc_pkg;
    // register byte addresses (word aligned)
    localparam logic [7:0] ADDR_STATUS_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    // status/control field positions
    localparam int BIT_LOSS_OF_LOCK = 7;
    localparam int BIT_LOCKED = 6;
    localparam int BIT_LOOP_SRC = 5;
    localparam int BIT_REF_SRC = 4;
    localparam int BIT_MODE_HI = 3;
    localparam int BIT_MODE_LO = 2;
    localparam int BIT_OSC_READY = 1;
    localparam int BIT_FINE_TRIM = 0;
    // control register field positions
    localparam int BIT_LOL_IRQ_EN = 0;
    localparam logic [7:0] STATUS_CTRL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // clock mode encodings
    localparam logic [1:0] MODE_FLL = 2'h0;
    localparam logic [1:0] MODE_INTERNAL = 2'h1;
    localparam logic [1:0] MODE_EXTERNAL = 2'h2;
    localparam logic [1:0] MODE_PLL = 2'h3;
    // irq status bit: loss of lock event
    localparam int IRQ_BIT_LOL = 0;
    // timing
    localparam int CLOCK_HZ = 20000000;
    localparam int SYNC_STAGES = 2;
    localparam int OSC_STARTUP_CYCLES = 4096;

    // generator-side configuration, as seen by this block
    typedef struct packed {
        logic referenceSelect;
        logic loopSelect;
        logic [2:0] referenceDivider;
        logic [7:0] trim;
        logic [3:0] vcoDivider;
        logic [1:0] clockSelect;
        logic oscillatorRequest;
        logic externalRefEnable;
        logic lowPower;
    } cgsc_cfg_t;

    // analog loop and mode state reported in
    typedef struct packed {
        logic fllEnabled;
        logic pllEnabled;
        logic loopLocked;
        logic stopEntry;
        logic oscClockTick;
    } cgsc_hw_t;
endpackage : cgsc_pkg

//--- cgsc_sync.sv
`timescale 1ns/1ps
module cgsc_sync #(
    parameter int WIDTH = 1,
    parameter int STAGES = 2
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] chain [STAGES];

    // first stage feeds only the next stage
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < STAGES; i++)
            begin
                chain[i] <= '0;
            end
        end
        else
        begin
            chain[0] <= din;
            for (int i = 1; i < STAGES; i++)
            begin
                chain[i] <= chain[i-1];
            end
        end
    end

    assign dout = chain[STAGES-1];
endmodule : cgsc_sync

//--- cgsc_status_ctrl.sv
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module cgsc_status_ctrl #(
    parameter int OSC_STARTUP = cgsc_pkg::OSC_STARTUP_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // generator configuration and hardware state
    input wire cgsc_pkg::cgsc_cfg_t cfg,
    input wire cgsc_pkg::cgsc_hw_t hw,
    // outputs
    output logic fineTrim,
    output logic lockDetectEnable,
    output logic irq
);
    typedef enum logic [2:0] {
        CGSC_IDLE = 3'b001,
        CGSC_COUNT = 3'b010,
        CGSC_READY = 3'b100
    } cgsc_osc_t;

    function automatic logic cgscIsInternalMode(input logic [1:0] mode, input logic refInt,
        input logic pll);
        cgscIsInternalMode = refInt && !pll &&
            (mode == cgsc_pkg::MODE_FLL || mode == cgsc_pkg::MODE_INTERNAL);
    endfunction : cgscIsInternalMode

    function automatic logic cgscIsPllMode(input logic [1:0] mode, input logic pll);
        cgscIsPllMode = pll && (mode == cgsc_pkg::MODE_PLL || mode == cgsc_pkg::MODE_EXTERNAL);
    endfunction : cgscIsPllMode

    logic lossOfLock;
    logic locked;
    logic control;
    logic irqStatus;
    logic irqMask;
    logic [31:0] readData;
    logic ackQ;
    logic errQ;
    cgsc_pkg::cgsc_cfg_t cfgQ;
    logic lowPowerBypassQ;
    cgsc_osc_t oscState;
    cgsc_osc_t next_oscState;
    logic [12:0] oscCount;
    logic [3:0] syncIn;
    logic [3:0] syncOut;

    // bus decode
    wire request = cyc_i && stb_i && !ackQ && !errQ;
    wire hitStatus = adr_i == cgsc_pkg::ADDR_STATUS_CTRL;
    wire hitControl = adr_i == cgsc_pkg::ADDR_CONTROL;
    wire hitIrqStatus = adr_i == cgsc_pkg::ADDR_IRQ_STATUS;
    wire hitIrqMask = adr_i == cgsc_pkg::ADDR_IRQ_MASK;
    wire mapped = hitStatus || hitControl || hitIrqStatus || hitIrqMask;
    wire writeLane0 = request && we_i && sel_i[0];
    wire writeStatus = writeLane0 && hitStatus;
    wire writeControl = writeLane0 && hitControl;
    wire writeIrqStatus = writeLane0 && hitIrqStatus;
    wire writeIrqMask = writeLane0 && hitIrqMask;

    assign syncIn = {cfg.loopSelect, cfg.referenceSelect, cfg.clockSelect};
    cgsc_sync #(
        .WIDTH(4),
        .STAGES(cgsc_pkg::SYNC_STAGES)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .din(syncIn),
        .dout(syncOut)
    );
    wire loopSrc = syncOut[3];
    wire refSrc = syncOut[2];
    wire [1:0] modeStatus = syncOut[1:0];

    // detection off with both loops off
    assign lockDetectEnable = hw.fllEnabled || hw.pllEnabled;

    // low-power bypass: bypass select with lp set
    wire lowPowerBypass = cfg.lowPower &&
        (modeStatus == cgsc_pkg::MODE_INTERNAL || modeStatus == cgsc_pkg::MODE_EXTERNAL);

    wire cfgChange = (cfg.referenceSelect != cfgQ.referenceSelect) ||
        (cfg.loopSelect != cfgQ.loopSelect) ||
        (cfg.referenceDivider != cfgQ.referenceDivider) ||
        ((cfg.trim != cfgQ.trim || fineTrim != cfgQ.lowPower) &&
        cgscIsInternalMode(modeStatus, refSrc, loopSrc)) ||
        ((cfg.vcoDivider != cfgQ.vcoDivider) && cgscIsPllMode(modeStatus, loopSrc));

    wire lockDrop = cfgChange || hw.stopEntry || (lowPowerBypass && !lowPowerBypassQ);
    wire lockHold = lowPowerBypass || !lockDetectEnable;

    // loss only after lock was held
    wire lossEvent = lockDetectEnable && locked && !hw.loopLocked && !lockDrop;

    wire extUsed = cfg.externalRefEnable || !cgscIsInternalMode(modeStatus, refSrc, loopSrc);
    wire oscClear = !cfg.oscillatorRequest ||
        (cgscIsInternalMode(modeStatus, refSrc, loopSrc) && !cfg.externalRefEnable);

    always_comb
    begin
        next_oscState = oscState;
        case (oscState)
            CGSC_IDLE:
            begin
                if (cfg.oscillatorRequest && extUsed)
                begin
                    next_oscState = CGSC_COUNT;
                end
            end
            CGSC_COUNT:
            begin
                if (oscClear)
                begin
                    next_oscState = CGSC_IDLE;
                end
                else if (oscCount == 13'(OSC_STARTUP - 1) && hw.oscClockTick)
                begin
                    next_oscState = CGSC_READY;
                end
            end
            CGSC_READY:
            begin
                if (oscClear)
                begin
                    next_oscState = CGSC_IDLE;
                end
            end
            default:
            begin
                next_oscState = CGSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            oscState <= CGSC_IDLE;
            oscCount <= 13'h0000;
        end
        else
        begin
            oscState <= next_oscState;
            // start-up cycles counted on oscillator ticks
            if (oscState != CGSC_COUNT)
            begin
                oscCount <= 13'h0000;
            end
            else if (hw.oscClockTick)
            begin
                oscCount <= oscCount + 13'h0001;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            locked <= 1'b0;
            cfgQ <= '0;
            lowPowerBypassQ <= 1'b0;
        end
        else
        begin
            cfgQ <= cfg;
            cfgQ.lowPower <= fineTrim;
            lowPowerBypassQ <= lowPowerBypass;
            if (lockDrop || lockHold)
            begin
                locked <= 1'b0;
            end
            else
            begin
                locked <= hw.loopLocked;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            lossOfLock <= cgsc_pkg::STATUS_CTRL_RESET[cgsc_pkg::BIT_LOSS_OF_LOCK];
            fineTrim <= cgsc_pkg::STATUS_CTRL_RESET[cgsc_pkg::BIT_FINE_TRIM];
            control <= cgsc_pkg::CONTROL_RESET[cgsc_pkg::BIT_LOL_IRQ_EN];
            irqStatus <= 1'b0;
            irqMask <= 1'b0;
        end
        else
        begin
            if (lossEvent)
            begin
                lossOfLock <= 1'b1;
            end
            else if (writeStatus && dat_i[cgsc_pkg::BIT_LOSS_OF_LOCK])
            begin
                lossOfLock <= 1'b0;
            end
            if (writeStatus)
            begin
                fineTrim <= dat_i[cgsc_pkg::BIT_FINE_TRIM];
            end
            if (writeControl)
            begin
                control <= dat_i[cgsc_pkg::BIT_LOL_IRQ_EN];
            end
            if (lossEvent)
            begin
                irqStatus <= 1'b1;
            end
            else if (writeIrqStatus && dat_i[cgsc_pkg::IRQ_BIT_LOL])
            begin
                irqStatus <= 1'b0;
            end
            if (writeIrqMask)
            begin
                irqMask <= dat_i[cgsc_pkg::IRQ_BIT_LOL];
            end
        end
    end

    // enable acts only with flag set
    assign irq = (lossOfLock && control) || (irqStatus && irqMask);

    wire [7:0] statusByte = {lossOfLock, locked, loopSrc, refSrc, modeStatus,
        oscState == CGSC_READY, fineTrim};
    assign readData = hitStatus ? {24'h000000, statusByte} :
        hitControl ? {31'h00000000, control} :
        hitIrqStatus ? {31'h00000000, irqStatus} :
        hitIrqMask ? {31'h00000000, irqMask} : 32'h00000000;

    // one-cycle answer, error for unmapped addresses
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ackQ <= 1'b0;
            errQ <= 1'b0;
            dat_o <= 32'h00000000;
        end
        else
        begin
            ackQ <= request && mapped;
            errQ <= request && !mapped;
            dat_o <= (request && !we_i) ? readData : 32'h00000000;
        end
    end

    assign ack_o = ackQ;
    assign err_o = errQ;
endmodule : cgsc_status_ctrl

//--- cgsc_status_ctrl_checker.sv
`timescale 1ns/1ps
module cgsc_status_ctrl_checker #(
    parameter int OSC_STARTUP = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // wishbone
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic err_o,
    // generator side
    input wire cgsc_pkg::cgsc_cfg_t cfg,
    input wire cgsc_pkg::cgsc_hw_t hw,
    input wire logic fineTrim,
    input wire logic lockDetectEnable,
    input wire logic irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic [2:0] quiet;
    logic [3:0] prevStat;
    wire [3:0] cfgStat = {cfg.loopSelect, cfg.referenceSelect, cfg.clockSelect};
    wire take = cyc_i && stb_i && !ack_o && !err_o;
    wire mapped = adr_i[7:4] == 4'h0 && adr_i[1:0] == 2'h0;
    wire isSc = adr_i == cgsc_pkg::ADDR_STATUS_CTRL;
    wire rdSc = take && !we_i && isSc;
    // status fields lag cfg, so only judge reads after a quiet spell
    always_ff @(posedge core_clk)
    begin
        prevStat <= cfgStat;
        if (rst || cfgStat != prevStat)
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end
    a_ack_mapped: assert property (take && mapped |=> ack_o && !err_o)
        else $error("no ack");
    a_err_unmapped: assert property (take && !mapped |=> err_o && !ack_o)
        else $error("no err");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("long ack");
    a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper bits set");
    a_detect_off: assert property (lockDetectEnable == (hw.fllEnabled || hw.pllEnabled))
        else $error("detect enable wrong");
    a_trim_write: assert property (take && we_i && sel_i[0] && isSc |=> fineTrim == $past(dat_i[0]))
        else $error("trim not written");
    a_trim_hold: assert property (!(take && we_i && sel_i[0] && isSc) |=> $stable(fineTrim))
        else $error("trim moved");
    a_lock_idle: assert property (rdSc && !lockDetectEnable && !$past(lockDetectEnable) |=> !dat_o[6])
        else $error("lock without detect");
    a_status_sync: assert property (rdSc && quiet >= 3'h4 |=> dat_o[5:2] == $past(cfgStat))
        else $error("status fields wrong");
    a_osc_drop: assert property (rdSc && !cfg.oscillatorRequest && !$past(cfg.oscillatorRequest) |=> !dat_o[1])
        else $error("osc ready stuck");
    cover property (take && we_i && mapped);
    cover property (err_o);
    cover property (irq);
    cover property (rdSc && quiet >= 3'h4);
endmodule : cgsc_status_ctrl_checker

bind cgsc_status_ctrl cgsc_status_ctrl_checker #(.OSC_STARTUP(OSC_STARTUP)) chk (
    .core_clk(core_clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .cfg(cfg),
    .hw(hw), .fineTrim(fineTrim), .lockDetectEnable(lockDetectEnable), .irq(irq)
);

//--- test_cgsc_status_ctrl.sv
`timescale 1ns/1ps
module test_cgsc_status_ctrl;
    localparam logic [7:0] SC = cgsc_pkg::ADDR_STATUS_CTRL;
    logic core_clk, rst, cyc, stb, we, ack, err, fineTrim, lockDetEn, irq, rdErr, s;
    logic [7:0] adr, d;
    logic [3:0] sel;
    logic [31:0] datW, datR, rdData;
    cgsc_pkg::cgsc_cfg_t cfg;
    cgsc_pkg::cgsc_hw_t hw;
    int errors, nTests, seed, lol, lk, osc, ft;
    cgsc_status_ctrl #(.OSC_STARTUP(4)) DUT (
        .core_clk(core_clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack), .err_o(err), .cfg(cfg), .hw(hw),
        .fineTrim(fineTrim), .lockDetectEnable(lockDetEn), .irq(irq)
    );
    initial
    begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask : tick
    // one classic cycle, held until ack or err is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v, input logic e);
        int n;
        n = 0;
        @(posedge core_clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        sel <= {3'h0, e};
        datW <= {24'h000000, v};
        do
        begin
            @(posedge core_clk);
            n++;
        end while (!(ack || err) && n < 20);
        if (n >= 20)
            errors++;
        rdData = datR;
        rdErr = err;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        wb(1'h0, a, 8'h00, 1'h1);
        check(rdData, {24'h000000, exp});
    endtask : rd
    task automatic chkStat;
        rd(SC, 8'(lol * 128 + lk * 64 + cfg.loopSelect * 32 + cfg.referenceSelect * 16
            + cfg.clockSelect * 4 + osc * 2 + ft));
    endtask : chkStat
    task automatic chkIrq(input int e);
        @(negedge core_clk);
        check({31'h0, irq}, 32'(e));
        @(posedge core_clk);
    endtask : chkIrq
    initial
    begin
        seed = 93527;
        errors = 0;
        nTests = 0;
        lol = 0;
        lk = 0;
        osc = 0;
        ft = 0;
        rst = 1'h1;
        {cyc, stb, we, adr, sel, datW} = '0;
        cfg = '0;
        hw = '0;
        tick(6);
        rst <= 1'h0;
        rd(SC, 8'h00);
        rd(cgsc_pkg::ADDR_CONTROL, 8'h00);
        rd(cgsc_pkg::ADDR_IRQ_STATUS, 8'h00);
        rd(cgsc_pkg::ADDR_IRQ_MASK, 8'h00);
        wb(1'h1, 8'h10, 8'hFF, 1'h1);
        check({31'h0, rdErr}, 32'h1);
        for (int m = 0; m < 4; m++)
        begin
            cfg.clockSelect <= 2'(m);
            cfg.referenceSelect <= 1'(m);
            cfg.loopSelect <= 1'(m >> 1);
            tick(4);
            chkStat();
        end
        // random bytes, writes with lane 0 off must not land
        // bench loads fine trim itself
        for (int i = 0; i < 6; i++)
        begin
            d = 8'($random(seed));
            s = 1'($random(seed));
            wb(1'h1, SC, d, s);
            if (s)
                ft = d[0];
            chkStat();
            check({31'h0, fineTrim}, 32'(ft));
        end
        cfg <= '0;
        hw.fllEnabled <= 1'h1;
        hw.loopLocked <= 1'h1;
        tick(4);
        lk = 1;
        chkStat();
        hw.loopLocked <= 1'h0;
        tick(3);
        lol = 1;
        lk = 0;
        chkStat();
        rd(cgsc_pkg::ADDR_IRQ_STATUS, 8'h01);
        chkIrq(0);
        wb(1'h1, cgsc_pkg::ADDR_CONTROL, 8'h01, 1'h1);
        chkIrq(1);
        wb(1'h1, SC, 8'(ft), 1'h1);
        chkStat();
        wb(1'h1, SC, 8'(128 + ft), 1'h1);
        lol = 0;
        chkStat();
        chkIrq(0);
        wb(1'h1, cgsc_pkg::ADDR_IRQ_MASK, 8'h01, 1'h1);
        chkIrq(1);
        wb(1'h1, cgsc_pkg::ADDR_IRQ_STATUS, 8'h01, 1'h1);
        chkIrq(0);
        cfg.clockSelect <= cgsc_pkg::MODE_INTERNAL;
        cfg.referenceSelect <= 1'h1;
        cfg.lowPower <= 1'h1;
        hw.loopLocked <= 1'h1;
        tick(5);
        chkStat();
        cfg.lowPower <= 1'h0;
        tick(4);
        lk = 1;
        chkStat();
        // stop entry drops lock, not a loss event
        hw.stopEntry <= 1'h1;
        hw.loopLocked <= 1'h0;
        tick(1);
        hw.stopEntry <= 1'h0;
        lk = 0;
        chkStat();
        hw.loopLocked <= 1'h1;
        tick(2);
        lk = 1;
        chkStat();
        // trim change in an internal fll mode drops lock
        cfg.trim <= 8'($random(seed)) | 8'h01;
        hw.loopLocked <= 1'h0;
        tick(1);
        lk = 0;
        chkStat();
        hw.loopLocked <= 1'h1;
        tick(2);
        lk = 1;
        chkStat();
        hw.fllEnabled <= 1'h0;
        cfg.oscillatorRequest <= 1'h1;
        cfg.externalRefEnable <= 1'h1;
        lk = 0;
        for (int i = 0; i < 8; i++)
        begin
            hw.oscClockTick <= 1'h1;
            tick(1);
            hw.oscClockTick <= 1'h0;
            tick(1);
            if (i == 1)
                chkStat();
        end
        osc = 1;
        chkStat();
        check({31'h0, lockDetEn}, 32'h0);
        cfg.oscillatorRequest <= 1'h0;
        osc = 0;
        tick(2);
        chkStat();
        complete_run();
    end
    // a run still going after 3000 cycles ends as a failure
    initial
    begin
        tick(3000);
        errors++;
        complete_run();
    end
endmodule : test_cgsc_status_ctrl
